// ---- relay_output_source_select_bench.sv ----
// Self-checking bench for the relay output source selector
module relay_output_source_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, fault_valid_i = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, relay_output_first, relay_output_second;
    logic relay_output_third, coil_on;
    logic [15:0] main_sw_i = 16'h0, drv_sw1_i = 16'h0, drv_sw2_i = 16'h0;
    logic [15:0] spd_sw_i = 16'h0, timed_sw_i = 16'h0, supv_sw_i = 16'h0;
    logic [15:0] fault_code_i = 16'h0;
    logic [4:0] focc;
    int bad_count = 0, total_checks = 0, n, k;
    int pick [5] = '{0, 1, 6, 9, 11};
    logic [15:0] flt [13] = '{16'h2310, 16'h3210, 16'h2381, 16'h4110,
        16'h4210, 16'h4290, 16'h42F1, 16'h4310, 16'h4380, 16'h3220,
        16'h4981, 16'h4982, 16'h5090};
    logic [4:0] grp [13] = '{5'h01, 5'h02, 5'h04, 5'h04, 5'h04, 5'h04,
        5'h04, 5'h04, 5'h04, 5'h08, 5'h10, 5'h10, 5'h00};
    always #2 aclk = ~aclk;
    rosel_top #(.STEP_CYCLES(4)) DUT (.*);
    ross_coil coil (.aclk, .drive(relay_output_second), .coil_on);
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task over;
        bad_count++;
        end_sim;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (e !== s) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    // Bus write: address and data offered together, each freed when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
        if (n == 40) over;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        {rd, rsp} = {s_axi_rdata, s_axi_rresp};
        if (n == 40) over;
    endtask
    function logic src_exp(input logic [5:0] c);
        case (c) inside
            6'h00, 6'h01: return c[0];
            6'h0A: return spd_sw_i[2];
            6'h0B: return spd_sw_i[0];
            6'h0C: return drv_sw2_i[10];
            6'h0D: return main_sw_i[7];
            6'h0E: return main_sw_i[3];
            6'h0F: return !main_sw_i[3];
            6'h10: return main_sw_i[3] | main_sw_i[7];
            [6'h11:6'h15]: return focc[c - 6'h11];
            6'h17: return drv_sw1_i[11];
            6'h18: return main_sw_i[9];
            [6'h1B:6'h1D]: return timed_sw_i[c - 6'h1B];
            [6'h21:6'h23]: return supv_sw_i[c - 6'h21];
            6'h27: return drv_sw2_i[13];
            default: return 1'b0;
        endcase
    endfunction
    initial begin
        void'($urandom(47164));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(8'h08);
        chk("third source reset", 32'hF, rd);
        rd_reg(8'h2C);
        chk("unmapped read", 32'h2, 32'(rsp));
        chk("unmapped data", 32'h0, rd);
        wr(8'h2C, 32'h1);
        chk("unmapped write", 32'h2, 32'(rsp));
        $display("test registers done");
        for (int c = 0; c < 64; c++) begin
            wr(8'h24, 32'h1F);
            wr(8'h00, 32'(c));
            @(posedge aclk);
            {main_sw_i, drv_sw1_i} <= $urandom;
            {drv_sw2_i, spd_sw_i} <= $urandom;
            {timed_sw_i, supv_sw_i} <= $urandom;
            k = (c >= 17 && c <= 21) ? pick[c - 17] : $urandom % 13;
            fault_code_i <= flt[k];
            fault_valid_i <= 1'b1;
            @(posedge aclk);
            fault_valid_i <= 1'b0;
            focc = grp[k];
            repeat (3) @(posedge aclk);
            chk("relay 1", 32'(src_exp(6'(c))),
                32'(relay_output_first));
            chk("relay 3", 32'(!main_sw_i[3]),
                32'(relay_output_third));
        end
        $display("test codes done");
        wr(8'h14, 32'h3);
        wr(8'h04, 32'h1);
        for (n = 0; n < 40 && relay_output_second !== 1'b1; n++)
            @(posedge aclk);
        chk("on delay in window", 32'h1, 32'(n >= 10 && n <= 13));
        repeat (2) @(posedge aclk);
        chk("coil energized", 32'h1, 32'(coil_on));
        wr(8'h18, 32'h2);
        wr(8'h04, 32'h0);
        for (n = 0; n < 40 && relay_output_second !== 1'b0; n++)
            @(posedge aclk);
        chk("off delay in window", 32'h1, 32'(n >= 6 && n <= 9));
        repeat (2) @(posedge aclk);
        chk("coil released", 32'h0, 32'(coil_on));
        $display("test delay done");
        end_sim;
    end
endmodule
bind rosel_top ross_properties u_props (.*);

// ---- rosel_delay.sv ----
// On and off delay stage driving one relay output
`include "rosel_params.svh"
module rosel_delay
    import rosel_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic tick_i, // One pulse per 0.1 s step
    input wire logic src_i, // Selected source level
    input wire rosel_dly_t on_dly_i, // Activation delay in steps
    input wire rosel_dly_t off_dly_i, // Deactivation delay in steps
    output logic relay_o // Relay energize level
);
    rosel_dly_t cnt_q;
    rosel_dly_t dly;

    // Delay applying to the pending change
    assign dly = src_i ? on_dly_i : off_dly_i;

    // Relay follows source once it has differed for the delay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            relay_o <= 1'b0;
            cnt_q <= `ROSEL_RST_DLY;
        end else if (src_i == relay_o) begin
            cnt_q <= `ROSEL_RST_DLY;
        end else if (cnt_q >= dly) begin
            relay_o <= src_i;
            cnt_q <= `ROSEL_RST_DLY;
        end else if (tick_i) begin
            cnt_q <= cnt_q + 15'h0001;
        end
    end
endmodule

// ---- rosel_mux.sv ----
// Source multiplexer for one relay output
`include "rosel_params.svh"
module rosel_mux
    import rosel_pkg::*;
(
    input wire rosel_code_t sel_i, // Selection code
    input wire logic [15:0] main_sw_i, // Main status word
    input wire logic [15:0] drv_sw1_i, // Drive status word 1
    input wire logic [15:0] drv_sw2_i, // Drive status word 2
    input wire logic [15:0] spd_sw_i, // Speed control status word
    input wire logic [2:0] timed_i, // Timed function bits
    input wire logic [2:0] supv_i, // Supervision bits
    input wire logic [4:0] focc_i, // Fault-occurred group flags
    output logic src_o // Selected source level
);
    // Pure combinational pick, re-evaluated continuously
    always_comb begin
        unique case (sel_i)
            `ROSEL_C_OFF: src_o = 1'b0;
            `ROSEL_C_ON: src_o = 1'b1;
            `ROSEL_C_REVERSE: src_o = spd_sw_i[`ROSEL_B_REVERSE];
            `ROSEL_C_ZERO_SPD: src_o = spd_sw_i[`ROSEL_B_ZERO_SPD];
            `ROSEL_C_ABOVE_LIM: src_o = drv_sw2_i[`ROSEL_B_ABOVE_LIM];
            `ROSEL_C_WARNING: src_o = main_sw_i[`ROSEL_B_WARNING];
            `ROSEL_C_FAULT: src_o = main_sw_i[`ROSEL_B_FAULT];
            `ROSEL_C_FAULT_N: src_o = ~main_sw_i[`ROSEL_B_FAULT];
            `ROSEL_C_FLT_WRN: src_o = main_sw_i[`ROSEL_B_FAULT] |
                main_sw_i[`ROSEL_B_WARNING];
            `ROSEL_C_OVERCUR: src_o = focc_i[ROSEL_G_OVERCUR];
            `ROSEL_C_OVERVOLT: src_o = focc_i[ROSEL_G_OVERVOLT];
            `ROSEL_C_DRV_TEMP: src_o = focc_i[ROSEL_G_DRV_TEMP];
            `ROSEL_C_UNDERVOLT: src_o = focc_i[ROSEL_G_UNDERVOLT];
            `ROSEL_C_MOT_TEMP: src_o = focc_i[ROSEL_G_MOT_TEMP];
            `ROSEL_C_LOC2: src_o = drv_sw1_i[`ROSEL_B_LOC2];
            `ROSEL_C_REMOTE: src_o = main_sw_i[`ROSEL_B_REMOTE];
            `ROSEL_C_TIMED1: src_o = timed_i[0];
            `ROSEL_C_TIMED2: src_o = timed_i[1];
            `ROSEL_C_TIMED3: src_o = timed_i[2];
            `ROSEL_C_SUPV1: src_o = supv_i[0];
            `ROSEL_C_SUPV2: src_o = supv_i[1];
            `ROSEL_C_SUPV3: src_o = supv_i[2];
            `ROSEL_C_START_DLY: src_o = drv_sw2_i[`ROSEL_B_START_DLY];
            default: src_o = 1'b0;
        endcase
    end
endmodule

// ---- rosel_params.svh ----
// Constants for the relay output source selector
`ifndef ROSEL_PARAMS_SVH
`define ROSEL_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ROSEL_OFS_SRC1 8'h00
`define ROSEL_OFS_SRC2 8'h04
`define ROSEL_OFS_SRC3 8'h08
`define ROSEL_OFS_ON1 8'h0C
`define ROSEL_OFS_OFF1 8'h10
`define ROSEL_OFS_ON2 8'h14
`define ROSEL_OFS_OFF2 8'h18
`define ROSEL_OFS_ON3 8'h1C
`define ROSEL_OFS_OFF3 8'h20
`define ROSEL_OFS_FOCC 8'h24
`define ROSEL_OFS_STAT 8'h28

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define ROSEL_RST_SRC1 6'h02
`define ROSEL_RST_SRC2 6'h07
`define ROSEL_RST_SRC3 6'h0F
`define ROSEL_RST_DLY 15'h0000
`define ROSEL_DLY_MAX 15'h7530

// ----------------------------------------------------------------
// Timing: one delay step is 0.1 s
// ----------------------------------------------------------------
`define ROSEL_CLK_MHZ 250
`define ROSEL_STEP_US 100000
`define ROSEL_STEP_CYCLES (`ROSEL_STEP_US * `ROSEL_CLK_MHZ)

// ----------------------------------------------------------------
// Selection codes
// ----------------------------------------------------------------
`define ROSEL_C_OFF 6'h00
`define ROSEL_C_ON 6'h01
`define ROSEL_C_REVERSE 6'h0A
`define ROSEL_C_ZERO_SPD 6'h0B
`define ROSEL_C_ABOVE_LIM 6'h0C
`define ROSEL_C_WARNING 6'h0D
`define ROSEL_C_FAULT 6'h0E
`define ROSEL_C_FAULT_N 6'h0F
`define ROSEL_C_FLT_WRN 6'h10
`define ROSEL_C_OVERCUR 6'h11
`define ROSEL_C_OVERVOLT 6'h12
`define ROSEL_C_DRV_TEMP 6'h13
`define ROSEL_C_UNDERVOLT 6'h14
`define ROSEL_C_MOT_TEMP 6'h15
`define ROSEL_C_LOC2 6'h17
`define ROSEL_C_REMOTE 6'h18
`define ROSEL_C_TIMED1 6'h1B
`define ROSEL_C_TIMED2 6'h1C
`define ROSEL_C_TIMED3 6'h1D
`define ROSEL_C_SUPV1 6'h21
`define ROSEL_C_SUPV2 6'h22
`define ROSEL_C_SUPV3 6'h23
`define ROSEL_C_START_DLY 6'h27

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define ROSEL_B_REVERSE 2
`define ROSEL_B_ZERO_SPD 0
`define ROSEL_B_ABOVE_LIM 10
`define ROSEL_B_WARNING 7
`define ROSEL_B_FAULT 3
`define ROSEL_B_LOC2 11
`define ROSEL_B_REMOTE 9
`define ROSEL_B_START_DLY 13

// ----------------------------------------------------------------
// Fault event codes
// ----------------------------------------------------------------
`define ROSEL_F_OVERCUR 16'h2310
`define ROSEL_F_OVERVOLT 16'h3210
`define ROSEL_F_UNDERVOLT 16'h3220
`define ROSEL_F_IGBT_OVL 16'h2381
`define ROSEL_F_CB_TEMP 16'h4110
`define ROSEL_F_IGBT_OT 16'h4210
`define ROSEL_F_COOLING 16'h4290
`define ROSEL_F_IGBT_TEMP 16'h42F1
`define ROSEL_F_EXCESS_T 16'h4310
`define ROSEL_F_EXCESS_DT 16'h4380
`define ROSEL_F_EXT_T1 16'h4981
`define ROSEL_F_EXT_T2 16'h4982

`endif

// ---- rosel_pkg.sv ----
// Types shared by the relay output source selector
package rosel_pkg;
    typedef logic [5:0] rosel_code_t;
    typedef logic [14:0] rosel_dly_t;
    // Index of each fault-occurred group flag
    typedef enum logic [2:0] {
        ROSEL_G_OVERCUR,
        ROSEL_G_OVERVOLT,
        ROSEL_G_DRV_TEMP,
        ROSEL_G_UNDERVOLT,
        ROSEL_G_MOT_TEMP
    } rosel_grp_t;
endpackage

// ---- rosel_top.sv ----
// Relay output source selector with AXI4-Lite register access
`include "rosel_params.svh"
module rosel_top
    import rosel_pkg::*;
#(
    parameter int STEP_CYCLES = `ROSEL_STEP_CYCLES
) (
    input wire logic aclk, // Clock, 250 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Write protection, unused
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Read protection, unused
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [15:0] main_sw_i, // Main status word
    input wire logic [15:0] drv_sw1_i, // Drive status word 1
    input wire logic [15:0] drv_sw2_i, // Drive status word 2
    input wire logic [15:0] spd_sw_i, // Speed control status word
    input wire logic [15:0] timed_sw_i, // Timed functions status
    input wire logic [15:0] supv_sw_i, // Supervision status
    input wire logic fault_valid_i, // Fault logged, one-cycle pulse
    input wire logic [15:0] fault_code_i, // Code of logged fault
    output logic relay_output_first, // Relay 1 energize
    output logic relay_output_second, // Relay 2 energize
    output logic relay_output_third // Relay 3 energize
);
    // Response codes and relay count
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int NRELAY = 3;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    rosel_code_t src_sel_q [NRELAY];
    rosel_dly_t on_dly_q [NRELAY];
    rosel_dly_t off_dly_q [NRELAY];
    logic [4:0] focc_q;
    logic [4:0] focc_set;
    logic [NRELAY-1:0] src_lvl;
    logic [NRELAY-1:0] relay;
    logic [24:0] pre_q;
    logic tick_q;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] wr_word;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;

    // ----------------------------------------------------------------
    // Step prescaler: one tick per 0.1 s
    // ----------------------------------------------------------------
    // Counter wraps at STEP_CYCLES so a tick lasts one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= 25'h0000000;
            tick_q <= 1'b0;
        end else if (pre_q >= 25'(STEP_CYCLES - 1)) begin
            pre_q <= 25'h0000000;
            tick_q <= 1'b1;
        end else begin
            pre_q <= pre_q + 25'h0000001;
            tick_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Fault-occurred group flags
    // ----------------------------------------------------------------
    // Decode a logged fault into its group
    always_comb begin
        focc_set = 5'h00;
        if (fault_valid_i) begin
            focc_set[ROSEL_G_OVERCUR] =
                (fault_code_i == `ROSEL_F_OVERCUR);
            focc_set[ROSEL_G_OVERVOLT] =
                (fault_code_i == `ROSEL_F_OVERVOLT);
            focc_set[ROSEL_G_DRV_TEMP] =
                (fault_code_i == `ROSEL_F_IGBT_OVL) ||
                (fault_code_i == `ROSEL_F_CB_TEMP) ||
                (fault_code_i == `ROSEL_F_IGBT_OT) ||
                (fault_code_i == `ROSEL_F_COOLING) ||
                (fault_code_i == `ROSEL_F_IGBT_TEMP) ||
                (fault_code_i == `ROSEL_F_EXCESS_T) ||
                (fault_code_i == `ROSEL_F_EXCESS_DT);
            focc_set[ROSEL_G_UNDERVOLT] =
                (fault_code_i == `ROSEL_F_UNDERVOLT);
            focc_set[ROSEL_G_MOT_TEMP] =
                (fault_code_i == `ROSEL_F_EXT_T1) ||
                (fault_code_i == `ROSEL_F_EXT_T2);
        end
    end

    // Sticky flags, write one to clear, a new event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            focc_q <= 5'h00;
        end else if (wr_go && wr_addr == `ROSEL_OFS_FOCC) begin
            focc_q <= (focc_q & ~wr_word[4:0]) | focc_set;
        end else begin
            focc_q <= focc_q | focc_set;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    // Write happens once address and data are both present
    assign wr_go = (aw_held_q || (s_axi_awvalid && s_axi_awready)) &&
        (w_held_q || (s_axi_wvalid && s_axi_wready)) &&
        !s_axi_bvalid;
    assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;

    // Hold address and data until both have arrived
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // Ready while the channel slot is free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q &&
                !s_axi_bvalid && !wr_go &&
                !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_q &&
                !s_axi_bvalid && !wr_go &&
                !(s_axi_wvalid && s_axi_wready);
        end
    end

    // Write response follows the completed write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Merge byte strobes into a word for the decoded register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Delay values above the documented maximum are clamped
    function automatic rosel_dly_t clamp(input logic [31:0] v);
        if (v > 32'(`ROSEL_DLY_MAX)) begin
            return `ROSEL_DLY_MAX;
        end
        return v[14:0];
    endfunction

    // Address hit check and strobe-masked write word
    always_comb begin
        wr_word = 32'h00000000;
        unique case (wr_addr)
            `ROSEL_OFS_SRC1,
            `ROSEL_OFS_SRC2,
            `ROSEL_OFS_SRC3,
            `ROSEL_OFS_ON1,
            `ROSEL_OFS_OFF1,
            `ROSEL_OFS_ON2,
            `ROSEL_OFS_OFF2,
            `ROSEL_OFS_ON3,
            `ROSEL_OFS_OFF3,
            `ROSEL_OFS_FOCC,
            `ROSEL_OFS_STAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        wr_word = merge(32'h00000000, wr_data, wr_strb);
    end

    // Selection codes, reset to the documented defaults
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_sel_q[0] <= `ROSEL_RST_SRC1;
            src_sel_q[1] <= `ROSEL_RST_SRC2;
            src_sel_q[2] <= `ROSEL_RST_SRC3;
        end else if (wr_go) begin
            for (int i = 0; i < NRELAY; i++) begin
                if (wr_addr == `ROSEL_OFS_SRC1 + 8'(4 * i) &&
                    wr_strb[0]) begin
                    src_sel_q[i] <= wr_data[5:0];
                end
            end
        end
    end

    // On and off delay settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NRELAY; i++) begin
                on_dly_q[i] <= `ROSEL_RST_DLY;
                off_dly_q[i] <= `ROSEL_RST_DLY;
            end
        end else if (wr_go) begin
            for (int i = 0; i < NRELAY; i++) begin
                if (wr_addr == `ROSEL_OFS_ON1 + 8'(8 * i)) begin
                    on_dly_q[i] <= clamp(merge({17'h00000, on_dly_q[i]},
                        wr_data, wr_strb));
                end
                if (wr_addr == `ROSEL_OFS_OFF1 + 8'(8 * i)) begin
                    off_dly_q[i] <= clamp(merge({17'h00000, off_dly_q[i]},
                        wr_data, wr_strb));
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    // Read mux over the register map
    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `ROSEL_OFS_SRC1: rd_word[5:0] = src_sel_q[0];
            `ROSEL_OFS_SRC2: rd_word[5:0] = src_sel_q[1];
            `ROSEL_OFS_SRC3: rd_word[5:0] = src_sel_q[2];
            `ROSEL_OFS_ON1: rd_word[14:0] = on_dly_q[0];
            `ROSEL_OFS_OFF1: rd_word[14:0] = off_dly_q[0];
            `ROSEL_OFS_ON2: rd_word[14:0] = on_dly_q[1];
            `ROSEL_OFS_OFF2: rd_word[14:0] = off_dly_q[1];
            `ROSEL_OFS_ON3: rd_word[14:0] = on_dly_q[2];
            `ROSEL_OFS_OFF3: rd_word[14:0] = off_dly_q[2];
            `ROSEL_OFS_FOCC: rd_word[4:0] = focc_q;
            `ROSEL_OFS_STAT: rd_word = {25'h0000000, src_lvl, 1'b0, relay};
            default: rd_hit = 1'b0;
        endcase
    end

    // One read at a time, data one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Relay channels
    // ----------------------------------------------------------------
    // One selector and one delay stage per relay
    for (genvar g = 0; g < NRELAY; g++) begin : g_relay
        rosel_mux u_mux (
            .sel_i(src_sel_q[g]),
            .main_sw_i(main_sw_i),
            .drv_sw1_i(drv_sw1_i),
            .drv_sw2_i(drv_sw2_i),
            .spd_sw_i(spd_sw_i),
            .timed_i(timed_sw_i[2:0]),
            .supv_i(supv_sw_i[2:0]),
            .focc_i(focc_q),
            .src_o(src_lvl[g])
        );
        rosel_delay u_dly (
            .aclk(aclk),
            .aresetn(aresetn),
            .tick_i(tick_q),
            .src_i(src_lvl[g]),
            .on_dly_i(on_dly_q[g]),
            .off_dly_i(off_dly_q[g]),
            .relay_o(relay[g])
        );
    end

    // Relay pins come from the delay stage flops
    assign relay_output_first = relay[0];
    assign relay_output_second = relay[1];
    assign relay_output_third = relay[2];
endmodule

// ---- ross_coil.sv ----
// Relay coil driver model at the far side of one relay output
module ross_coil (
    input wire logic aclk, // Clock
    input wire logic drive, // Energize request
    output logic coil_on // Coil state
);
    timeunit 1ns;
    timeprecision 1ps;
    // Armature pulls in or drops out one cycle after the drive changes
    always_ff @(posedge aclk) begin
        coil_on <= drive;
    end
endmodule

// ---- ross_properties.sv ----
// Assertions on the first relay output of the source selector
module ross_properties (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic s_axi_wvalid, // Write data valid
    input wire logic s_axi_wready, // Write data ready
    input wire logic [15:0] main_sw_i, // Main status word
    input wire logic [15:0] spd_sw_i, // Speed status word
    input wire logic [15:0] timed_sw_i, // Timed functions status
    input wire logic fault_valid_i, // Fault logged
    input wire logic [15:0] fault_code_i, // Logged fault code
    input wire logic relay_output_first // Relay 1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] code_q;
    wire logic src1_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_awaddr == 8'h00;
    // Mirror of the first source code; the bench sends both halves at once
    always_ff @(posedge aclk) begin
        if (!aresetn) code_q <= 6'h02;
        else if (src1_wr) code_q <= s_axi_wdata[5:0];
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_fixed_level: assert property (code_q <= 6'h01 |=>
        relay_output_first == $past(code_q[0])) else $error("fixed level");
    a_reverse_bit: assert property (code_q == 6'h0A |=>
        relay_output_first == $past(spd_sw_i[2])) else $error("reverse");
    a_fault_direct: assert property (code_q == 6'h0E |=>
        relay_output_first == $past(main_sw_i[3])) else $error("fault");
    a_fault_invert: assert property (code_q == 6'h0F |=>
        relay_output_first == !$past(main_sw_i[3])) else $error("no fault");
    a_fault_or_warn: assert property (code_q == 6'h10 |=>
        relay_output_first == ($past(main_sw_i[3]) | $past(main_sw_i[7])))
        else $error("fault or warning");
    a_timed_bits: assert property (code_q inside {[6'h1B:6'h1D]} |=>
        relay_output_first == (($past(timed_sw_i[2:0]) >>
        ($past(code_q) - 6'h1B)) & 3'h1)) else $error("timed bit");
    a_overcur_set: assert property (code_q == 6'h11 && fault_valid_i
        && fault_code_i == 16'h2310 |-> ##2 relay_output_first)
        else $error("overcurrent");
    a_reserved_off: assert property (code_q inside {[6'h02:6'h09],
        6'h16, 6'h19, 6'h1A, [6'h1E:6'h20], [6'h24:6'h26], [6'h28:6'h3F]}
        |=> !relay_output_first) else $error("reserved code drives");
endmodule
